/* design/mtc_codec.sv */
`timescale 1ns/1ps
// Codec over the register bus; DMA enters through the same bus as register
// writes. A two-entry skid buffer holds each finished result word until the
// consumer takes it, so a stalled consumer loses nothing.
module mtc_codec (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire mtc_pkg::mtc_req_t req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic res_valid_o,
   input wire logic res_ready_i,
   output mtc_pkg::mtc_word_t res_data_o,
   output logic busy_o
);
   // ****************************************
   // Code tables
   // ****************************************
   function automatic logic [5:0] enc36(input logic [3:0] n);
      logic [5:0] s;
      s = 6'h16;
      unique case (n)
         4'h0: s = 6'h16;
         4'h1: s = 6'h0D;
         4'h2: s = 6'h0E;
         4'h3: s = 6'h0B;
         4'h4: s = 6'h1C;
         4'h5: s = 6'h19;
         4'h6: s = 6'h1A;
         4'h7: s = 6'h13;
         4'h8: s = 6'h2C;
         4'h9: s = 6'h25;
         4'hA: s = 6'h26;
         4'hB: s = 6'h23;
         4'hC: s = 6'h34;
         4'hD: s = 6'h31;
         4'hE: s = 6'h32;
         4'hF: s = 6'h29;
      endcase
      return s;
   endfunction

   // Returns {bad, nibble}; inverse of enc36 by search
   function automatic logic [4:0] dec36(input logic [5:0] s);
      logic [4:0] r;
      r = 5'h10;
      for (int i = 0; i < 16; i++) begin
         if (enc36(4'(i)) == s) begin
            r = {1'b0, 4'(i)};
         end
      end
      return r;
   endfunction

   // Bit 1 -> 10, bit 0 -> 01; polarity is a guess to be confirmed
   function automatic logic [15:0] man_enc(input logic [7:0] b);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 8; i++) begin
         r[2*i +: 2] = b[i] ? 2'b10 : 2'b01;
      end
      return r;
   endfunction

   // Returns {bad, byte}; 00 and 11 pairs are invalid
   function automatic logic [8:0] man_dec(input logic [15:0] w);
      logic [8:0] r;
      r = 9'h000;
      for (int i = 0; i < 8; i++) begin
         r[i] = w[2*i+1];
         if (w[2*i+1] == w[2*i]) begin
            r[8] = 1'b1;
         end
      end
      return r;
   endfunction

   // ****************************************
   // Register bus decode
   // ****************************************
   logic [7:0] ctrl_r;
   mtc_pkg::mtc_word_t data_r;
   logic start_r;
   mtc_pkg::mtc_op_t op_r;
   logic sel;
   logic wr_ctrl;
   logic wr_low;
   logic wr_mid;
   logic wr_high;

   assign sel = req_i.page == mtc_pkg::MTC_PAGE;
   assign wr_ctrl = req_i.wr && sel && req_i.addr == mtc_pkg::MTC_ADDR_CTRL;
   assign wr_low = req_i.wr && sel && req_i.addr == mtc_pkg::MTC_ADDR_LOW;
   assign wr_mid = req_i.wr && sel && req_i.addr == mtc_pkg::MTC_ADDR_MID;
   assign wr_high = req_i.wr && sel && req_i.addr == mtc_pkg::MTC_ADDR_HIGH;

   // ****************************************
   // Codec datapath (one cycle)
   // ****************************************
   mtc_pkg::mtc_word_t res_nxt;
   logic bad_nxt;
   always_comb begin
      logic [4:0] n0;
      logic [4:0] n1;
      logic [4:0] n2;
      logic [4:0] n3;
      logic [8:0] m0;
      logic [15:0] e0;
      logic [15:0] e1;
      logic [23:0] s;
      n0 = 5'h00;
      n1 = 5'h00;
      n2 = 5'h00;
      n3 = 5'h00;
      m0 = 9'h000;
      e0 = 16'h0000;
      e1 = 16'h0000;
      s = 24'h000000;
      res_nxt = data_r;
      bad_nxt = 1'b0;
      if (ctrl_r[mtc_pkg::MTC_BIT_MODE]) begin
         if (op_r == mtc_pkg::MTC_OP_ENC) begin
            // Middle:low nibbles, most significant first
            s = {enc36(data_r.mid[7:4]), enc36(data_r.mid[3:0]),
                 enc36(data_r.low[7:4]), enc36(data_r.low[3:0])};
            res_nxt = s;
         end else begin
            s = data_r;
            n3 = dec36(s[23:18]);
            n2 = dec36(s[17:12]);
            n1 = dec36(s[11:6]);
            n0 = dec36(s[5:0]);
            res_nxt = {8'h00, n3[3:0], n2[3:0], n1[3:0], n0[3:0]};
            bad_nxt = n3[4] | n2[4] | n1[4] | n0[4];
         end
      end else begin
         if (op_r == mtc_pkg::MTC_OP_ENC) begin
            // Four bytes do not fit three registers: high gets mid's low nibble, expanded
            e1 = man_enc(data_r.mid);
            e0 = man_enc(data_r.low);
            s = {e1[7:0], e0};
            res_nxt = s;
         end else begin
            m0 = man_dec({data_r.mid, data_r.low});
            res_nxt = {8'h00, 8'h00, m0[7:0]};
            bad_nxt = m0[8];
         end
      end
   end

   // ****************************************
   // Two-entry result buffer
   // ****************************************
   mtc_pkg::mtc_word_t buf_r [2];
   logic [1:0] cnt_r;
   logic wptr_r;
   logic rptr_r;
   logic push;
   logic pop;
   assign push = ce_i && start_r && cnt_r != 2'd2;
   assign pop = ce_i && res_valid_o && res_ready_i;
   assign busy_o = start_r;

   // Buffer pointers and storage
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r <= 2'd0;
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
         buf_r[0] <= '0;
         buf_r[1] <= '0;
      end else begin
         if (push) begin
            buf_r[wptr_r] <= res_nxt;
            wptr_r <= ~wptr_r;
         end
         if (pop) begin
            rptr_r <= ~rptr_r;
         end
         cnt_r <= cnt_r + 2'(push) - 2'(pop);
      end
   end

   // Buffer outputs registered; with the buffer empty they load res_nxt directly
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         res_valid_o <= 1'b0;
         res_data_o <= '0;
      end else if (ce_i) begin
         if (!res_valid_o || res_ready_i) begin
            res_valid_o <= (cnt_r - 2'(pop)) != 2'd0 || push;
            if (cnt_r - 2'(pop) != 2'd0) begin
               res_data_o <= buf_r[rptr_r ^ pop];
            end else begin
               res_data_o <= res_nxt;
            end
         end
      end
   end

   // ****************************************
   // Control and data registers
   // ****************************************
   // Start request latched; stalls while the buffer is full
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         start_r <= 1'b0;
         op_r <= mtc_pkg::MTC_OP_ENC;
      end else if (ce_i) begin
         if (wr_ctrl && req_i.wdata[mtc_pkg::MTC_BIT_ENC]) begin
            start_r <= 1'b1;
            op_r <= mtc_pkg::MTC_OP_ENC;
         end else if (wr_ctrl && req_i.wdata[mtc_pkg::MTC_BIT_DEC]) begin
            start_r <= 1'b1;
            op_r <= mtc_pkg::MTC_OP_DEC;
         end else if (push) begin
            start_r <= 1'b0;
         end
      end
   end

   // Control: flags set by hardware win over a clearing write
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_r <= mtc_pkg::MTC_RESET_VAL;
      end else if (ce_i) begin
         if (wr_ctrl) begin
            ctrl_r[5:0] <= req_i.wdata[5:0] & mtc_pkg::MTC_CTRL_WMASK[5:0];
            if (req_i.wdata == 8'h00) begin
               ctrl_r[mtc_pkg::MTC_BIT_READY] <= 1'b0;
               ctrl_r[mtc_pkg::MTC_BIT_ERROR] <= 1'b0;
            end
         end else if (push) begin
            ctrl_r[mtc_pkg::MTC_BIT_ENC] <= 1'b0;
            ctrl_r[mtc_pkg::MTC_BIT_DEC] <= 1'b0;
         end
         if (push) begin
            ctrl_r[mtc_pkg::MTC_BIT_READY] <= 1'b1;
            if (bad_nxt) begin
               ctrl_r[mtc_pkg::MTC_BIT_ERROR] <= 1'b1;
            end
         end
      end
   end

   // Data registers; a finished result overwrites the written input
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_r <= '0;
      end else if (ce_i) begin
         if (push) begin
            data_r <= res_nxt;
         end else if (wr_low) begin
            data_r.low <= req_i.wdata;
         end else if (wr_mid) begin
            data_r.mid <= req_i.wdata;
         end else if (wr_high) begin
            data_r.high <= req_i.wdata;
         end
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 8'h00;
         rvalid_o <= 1'b0;
      end else if (ce_i) begin
         rvalid_o <= req_i.rd;
         rdata_o <= 8'h00;
         if (req_i.rd && sel) begin
            unique case (req_i.addr)
               mtc_pkg::MTC_ADDR_LOW: rdata_o <= data_r.low;
               mtc_pkg::MTC_ADDR_MID: rdata_o <= data_r.mid;
               mtc_pkg::MTC_ADDR_HIGH: rdata_o <= data_r.high;
               mtc_pkg::MTC_ADDR_CTRL: rdata_o <= ctrl_r;
               default: rdata_o <= 8'h00;
            endcase
         end
      end
   end
endmodule

/* include/mtc_pkg.sv */
// Operation
// - Writing one to control bit 5 starts an encode of the data registers.
// - Writing one to control bit 4 starts a decode of the data registers.
// - Control bit 0 picks Manchester (0) or three-of-six (1) scheme.
// - Control bit 1 selects big-endian byte order for DMA transfers; the codec only stores this bit and never uses it.
// - Control register at 0xC5, page 0x2, byte access, resets to zero.
// - Low data byte read/write at 0xC2, page 0x2, resets to zero.
// - Middle data byte read/write at 0xC3, page 0x2, resets to zero.
// - High data byte read/write at 0xC4, page 0x2, resets to zero.
// - Three-of-six turns each nibble into six bits: two bytes become three.
// - Fixed sixteen-entry nibble-to-symbol table; decode is its exact inverse.
// - Ready flag bit 7 on completion; error flag bit 6 on bad symbol.
// - In DMA decode an error does not stop processing; error stays set.
package mtc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] MTC_PAGE = 8'h02;
   localparam logic [7:0] MTC_ADDR_LOW = 8'hC2;
   localparam logic [7:0] MTC_ADDR_MID = 8'hC3;
   localparam logic [7:0] MTC_ADDR_HIGH = 8'hC4;
   localparam logic [7:0] MTC_ADDR_CTRL = 8'hC5;
   localparam logic [7:0] MTC_RESET_VAL = 8'h00;
   // ****************************************
   // Control fields
   // ****************************************
   localparam int MTC_BIT_READY = 7;
   localparam int MTC_BIT_ERROR = 6;
   localparam int MTC_BIT_ENC = 5;
   localparam int MTC_BIT_DEC = 4;
   localparam int MTC_BIT_DMA = 2;
   localparam int MTC_BIT_ENDIAN = 1;
   localparam int MTC_BIT_MODE = 0;
   localparam logic [7:0] MTC_CTRL_WMASK = 8'h37;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mtc_req_t;
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] mid;
      logic [7:0] low;
   } mtc_word_t;
   typedef enum logic {MTC_OP_ENC, MTC_OP_DEC} mtc_op_t;
endpackage

/* testbench/mtc_codec_monitor.sv */
`timescale 1ns/1ps
module mtc_codec_monitor (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire mtc_pkg::mtc_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic res_valid_o,
   input wire logic res_ready_i,
   input wire mtc_pkg::mtc_word_t res_data_o,
   input wire logic busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   // ****************************************
   // Start of an operation
   // ****************************************
   // Start only counts while idle; a start during busy keeps busy set and loads its op into op_r
   sequence start_s;
      ce_i && req_i.wr && req_i.page == mtc_pkg::MTC_PAGE && !busy_o
         && req_i.addr == mtc_pkg::MTC_ADDR_CTRL && (req_i.wdata[5] || req_i.wdata[4]);
   endsequence
   // ****************************************
   // Checks
   // ****************************************
   rd_answer_a: assert property (ce_i && req_i.rd |=> rvalid_o)
      else $error("read request not answered");
   // A low clock enable freezes the answer flag, so it may linger there
   rd_pulse_a: assert property (
      rvalid_o |-> ($past(ce_i) && $past(req_i.rd)) || (!$past(ce_i) && $past(rvalid_o)))
      else $error("read answer without request");
   unmapped_zero_a: assert property (
      ce_i && req_i.rd && req_i.page != mtc_pkg::MTC_PAGE |=> rdata_o == 8'h00)
      else $error("foreign page read not zero");
   start_busy_a: assert property (start_s |=> busy_o)
      else $error("start did not raise busy");
   start_done_a: assert property (start_s ##0 !res_valid_o |-> ##[1:3] res_valid_o)
      else $error("result late");
   busy_end_a: assert property ($fell(busy_o) |-> res_valid_o)
      else $error("busy ended without result");
   hold_word_a: assert property (
      res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
      else $error("stalled result lost");
   no_spurious_a: assert property ($rose(res_valid_o) |-> $past(busy_o))
      else $error("result without operation");
endmodule
bind mtc_codec mtc_codec_monitor u_mon (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
   .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_data_o(res_data_o),
   .busy_o(busy_o));

/* testbench/mtc_codec_tb_top.sv */
`timescale 1ns/1ps
module mtc_codec_tb_top;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic ce_i = 1'b1;
   logic stall = 1'b0;
   logic res_ready;
   logic res_valid;
   logic rvalid;
   logic busy;
   logic [7:0] rdata;
   mtc_pkg::mtc_req_t req = '0;
   mtc_pkg::mtc_word_t res_data;
   logic [15:0] d;
   int failures = 0;
   int total_checks = 0;
   int base;
   localparam logic [5:0] SYM [16] = '{6'h16, 6'h0D, 6'h0E, 6'h0B, 6'h1C, 6'h19, 6'h1A,
      6'h13, 6'h2C, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};
   initial forever #5 clk_sys_i = ~clk_sys_i;
   mtc_codec dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_i(req),
      .rdata_o(rdata), .rvalid_o(rvalid), .res_valid_o(res_valid), .res_ready_i(res_ready),
      .res_data_o(res_data), .busy_o(busy));
   mtc_sink_model u_sink (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .stall_i(stall),
      .res_valid_i(res_valid), .res_data_i(res_data), .res_ready_o(res_ready));
   // ****************************************
   // Helpers
   // ****************************************
   // Nibbles taken most significant first
   function automatic logic [23:0] enc36(input logic [15:0] v);
      return {SYM[v[15:12]], SYM[v[11:8]], SYM[v[7:4]], SYM[v[3:0]]};
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle request, then an idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] pg = 8'h02);
      @(negedge clk_sys_i);
      req = '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: v};
      @(negedge clk_sys_i);
      req = '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] pg = 8'h02);
      int n;
      @(negedge clk_sys_i);
      req = '{wr: 1'b0, rd: 1'b1, page: pg, addr: a, wdata: 8'h00};
      @(negedge clk_sys_i);
      req = '0;
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n == 4) failures++;
      if (n == 4) complete_run();
      chk({16'h0, rdata}, {16'h0, exp});
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n == 50) failures++;
      if (n == 50) complete_run();
   endtask
   task automatic wr3(input logic [23:0] v);
      wr(8'hC4, v[23:16]);
      wr(8'hC3, v[15:8]);
      wr(8'hC2, v[7:0]);
   endtask
   task automatic rd3(input logic [23:0] v);
      rd(8'hC4, v[23:16]);
      rd(8'hC3, v[15:8]);
      rd(8'hC2, v[7:0]);
   endtask
   task automatic op(input logic [7:0] c);
      wr(8'hC5, 8'h00);
      wr(8'hC5, c);
      wait_idle();
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (8) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      rd3(24'h000000);
      rd(8'hC5, 8'h00);
      $display("reset values done");
      wr3(24'h3CA55A);
      wr(8'hC2, 8'hFF, 8'h00);
      rd(8'hC2, 8'h00, 8'h00);
      rd3(24'h3CA55A);
      rd(8'hC6, 8'h00);
      ce_i = 1'b0;
      wr(8'hC2, 8'h11);
      ce_i = 1'b1;
      rd(8'hC2, 8'h5A);
      $display("register access done");
      // Every nibble code, encoded then decoded back
      for (int i = 0; i < 4; i++) begin
         d = 16'(16'h0123 + 16'h4444 * i);
         wr(8'hC3, d[15:8]);
         wr(8'hC2, d[7:0]);
         op(8'h21);
         rd(8'hC5, 8'h81);
         rd3(enc36(d));
         op(8'h11);
         rd3({8'h00, d});
      end
      chk(u_sink.got[6], enc36(16'hCDEF));
      $display("three of six done");
      wr3(24'h0003A5);
      op(8'h20);
      rd(8'hC5, 8'h80);
      rd3(24'h5A9966);
      op(8'h10);
      rd(8'hC2, 8'hA5);
      $display("manchester done");
      wr(8'hC5, 8'h00);
      wr3(24'h000000);
      wr(8'hC5, 8'h17);
      wait_idle();
      rd(8'hC5, 8'hC7);
      // First symbol invalid; the other three must still decode
      wr(8'hC5, 8'h00);
      wr3(24'h02934E);
      wr(8'hC5, 8'h17);
      wait_idle();
      rd(8'hC5, 8'hC7);
      rd3(24'h000F12);
      wr(8'hC5, 8'h00);
      rd(8'hC5, 8'h00);
      $display("error flag done");
      // Two results fill the buffer; the third start must wait
      stall = 1'b1;
      base = u_sink.got.size();
      for (int i = 0; i < 3; i++) begin
         wr(8'hC3, 8'(8'h12 * i));
         wr(8'hC2, 8'h34);
         wr(8'hC5, 8'h00);
         wr(8'hC5, 8'h21);
         if (i < 2) wait_idle();
      end
      repeat (6) @(negedge clk_sys_i);
      chk({23'h0, busy}, 24'h000001);
      stall = 1'b0;
      wait_idle();
      repeat (6) @(negedge clk_sys_i);
      for (int i = 0; i < 3; i++) begin
         chk(u_sink.got[base + i], enc36({8'(8'h12 * i), 8'h34}));
      end
      $display("buffer done");
      complete_run();
   end
endmodule

/* testbench/mtc_sink_model.sv */
`timescale 1ns/1ps
// Result consumer; a stall holds ready low so words pile up in the codec
module mtc_sink_model (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic stall_i,
   input wire logic res_valid_i,
   input wire mtc_pkg::mtc_word_t res_data_i,
   output logic res_ready_o
);
   mtc_pkg::mtc_word_t got[$];
   // Ready moves on the falling edge, clear of the sampling edge
   always @(negedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) res_ready_o <= 1'b0;
      else res_ready_o <= !stall_i;
   end
   // Log every accepted word in order
   always @(posedge clk_sys_i) begin
      if (res_valid_i && res_ready_o) got.push_back(res_data_i);
   end
endmodule
